/* File: common/swc_regs.svh */
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// ----------------------------------------
// timing figures
// ----------------------------------------
`define SWC_CLK_MHZ        25
`define SWC_WR_TIME_MS     5
`define SWC_STARTUP_US     100
`define SWC_US_PER_MS      1000

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define SWC_DATA_W         8
`define SWC_ADDR_W         16
`define SWC_BUF_DEPTH      16
`define SWC_FLAGS_W        2
`define SWC_FLAGS_INIT     2'h0
`define SWC_FLAG_AUTH      0
`define SWC_FLAG_ENC       1

`endif

/* File: common/swc_pkg.sv */
package swc_pkg;
  // ----------------------------------------
  // commit controller states, gray along reset-idle-load-chk-prog
  // ----------------------------------------
  typedef enum logic [2:0] {
    SWC_ST_RST  = 3'h0,
    SWC_ST_IDLE = 3'h1,
    SWC_ST_LOAD = 3'h3,
    SWC_ST_WCHK = 3'h2,
    SWC_ST_PROG = 3'h6
  } swc_state_t;
endpackage

/* File: common/swc_tmr_if.sv */
`timescale 1ns/1ps
// ----------------------------------------
// timer control bundle
// ----------------------------------------
interface swc_tmr_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface

/* File: design/swc_tmr.sv */
`timescale 1ns/1ps
module swc_tmr #(
  parameter int COUNT = 16
) (
  input  wire logic core_clk_in,  // 25 MHz clock
  input  wire logic srst_in,      // sync reset, high
  swc_tmr_if.tmr    t             // start / busy / done
);
  localparam int CW = $clog2(COUNT + 1);

  // refused at elaboration: a zero count would never raise done
  if (COUNT < 1) begin : g_bad_count
    $error("swc_tmr: COUNT must be at least 1");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          done_ff;
  logic          nxt_done;

  // ----------------------------------------
  // countdown, a start reloads even while running
  // ----------------------------------------
  always_comb begin
    nxt_done = 1'b0;
    nxt_cnt  = cnt_ff;
    if (t.start) begin
      nxt_cnt = CW'(COUNT);
    end else if (cnt_ff != '0) begin
      nxt_cnt  = cnt_ff - 1'b1;
      nxt_done = (cnt_ff == CW'(1));
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign t.busy = (cnt_ff != '0);
  assign t.done = done_ff;
endmodule

/* File: design/swc_commit.sv */
`timescale 1ns/1ps
`include "swc_regs.svh"

// Operation
// - write cycle timed from stop (secured writes: from good checksum) to done
// - refuse operation for delay after reset
// - reset clears all security flags
// - any tamper sensor disables the device
// - secured writes buffered until checksum arrives
// - good checksum commits, bad discards, crypto reset
// - bus activity before checksum aborts write
module swc_commit
  import swc_pkg::*;
#(
  parameter int DW         = `SWC_DATA_W,
  parameter int AW         = `SWC_ADDR_W,
  parameter int DEPTH      = `SWC_BUF_DEPTH,
  parameter int WR_CYCLES  = `SWC_WR_TIME_MS * `SWC_US_PER_MS * `SWC_CLK_MHZ,
  parameter int DLY_CYCLES = `SWC_STARTUP_US * `SWC_CLK_MHZ
) (
  input  wire logic          core_clk_in,     // 25 MHz clock
  input  wire logic          srst_in,         // sync reset, high (power-up)
  input  wire logic          volt_tamper_in,  // supply sensor trip
  input  wire logic          freq_tamper_in,  // clock frequency sensor trip
  input  wire logic          light_tamper_in, // light sensor trip
  input  wire logic          auth_set_in,     // pulse: authentication granted
  input  wire logic          enc_set_in,      // pulse: encryption activated
  input  wire logic          wr_cmd_in,       // pulse: user write command
  input  wire logic [AW-1:0] wr_addr_in,      // start address with wr_cmd_in
  input  wire logic          wr_byte_vld_in,  // pulse: write data byte
  input  wire logic [DW-1:0] wr_byte_in,      // data byte
  input  wire logic          stop_in,         // pulse: valid stop condition
  input  wire logic          chk_vld_in,      // pulse: checksum command received
  input  wire logic          chk_ok_in,       // checksum matched, with chk_vld_in
  input  wire logic          bus_act_in,      // pulse: any other bus activity
  output logic               ready_out,       // device may be operated
  output logic               disabled_out,    // tamper present
  output logic               busy_out,        // write cycle running
  output logic               auth_out,        // authentication flag
  output logic               enc_out,         // encryption flag
  output logic               crypto_rst_out,  // pulse: crypto engine reset
  output logic               abort_out,       // pulse: buffered write dropped
  output logic               nv_we_out,       // pulse: program one byte
  output logic [AW-1:0]      nv_addr_out,     // byte address
  output logic [DW-1:0]      nv_data_out      // byte data
);
  localparam int PW = $clog2(DEPTH + 1);

  // elaboration checks: the write cycle must outlast draining a full buffer
  if (DEPTH < 1 || DW < 1 || AW < 1) begin : g_bad_size
    $error("swc_commit: bad width or depth");
  end
  if (WR_CYCLES < DEPTH + 1) begin : g_bad_wr
    $error("swc_commit: WR_CYCLES too short for buffer");
  end
  if (DLY_CYCLES < 1) begin : g_bad_dly
    $error("swc_commit: DLY_CYCLES must be at least 1");
  end

  function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
    inc_ptr = p + 1'b1;
  endfunction

  // ----------------------------------------
  // timers
  // ----------------------------------------
  swc_tmr_if dly_t ();
  swc_tmr_if wr_t ();

  swc_tmr #(.COUNT(DLY_CYCLES)) u_dly (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .t           (dly_t.tmr)
  );

  swc_tmr #(.COUNT(WR_CYCLES)) u_wr (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .t           (wr_t.tmr)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  swc_state_t                 st_ff, nxt_st;
  logic                       arm_ff, nxt_arm;
  logic [`SWC_FLAGS_W-1:0]    flags_ff, nxt_flags;
  logic [DW-1:0]              buf_ff [DEPTH];
  logic [DW-1:0]              nxt_buf [DEPTH];
  logic [PW-1:0]              cnt_ff, nxt_cnt;
  logic [PW-1:0]              ptr_ff, nxt_ptr;
  logic [AW-1:0]              base_ff, nxt_base;
  logic                       ready_ff, disabled_ff, busy_ff;
  logic                       nxt_ready, nxt_disabled, nxt_busy;
  logic                       crst_ff, nxt_crst;
  logic                       abort_ff, nxt_abort;
  logic                       we_ff, nxt_we;
  logic [AW-1:0]              addr_ff, nxt_addr;
  logic [DW-1:0]              data_ff, nxt_data;
  logic                       tamper;
  logic                       secured;

  assign tamper  = volt_tamper_in | freq_tamper_in | light_tamper_in;
  assign secured = flags_ff[`SWC_FLAG_AUTH] | flags_ff[`SWC_FLAG_ENC];

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_arm     = arm_ff;
    nxt_flags   = flags_ff;
    nxt_buf     = buf_ff;
    nxt_cnt     = cnt_ff;
    nxt_ptr     = ptr_ff;
    nxt_base    = base_ff;
    nxt_crst    = 1'b0;
    nxt_abort   = 1'b0;
    nxt_we      = 1'b0;
    nxt_addr    = addr_ff;
    nxt_data    = data_ff;
    dly_t.start = 1'b0;
    wr_t.start  = 1'b0;
    case (st_ff)
      SWC_ST_RST: begin
        // delay starts only once every sensor reads normal again
        if (arm_ff && !tamper) begin
          dly_t.start = 1'b1;
          nxt_arm     = 1'b0;
        end else if (!arm_ff && dly_t.done) begin
          nxt_st = SWC_ST_IDLE;
        end
      end
      SWC_ST_IDLE: begin
        if (auth_set_in) nxt_flags[`SWC_FLAG_AUTH] = 1'b1;
        if (enc_set_in) nxt_flags[`SWC_FLAG_ENC] = 1'b1;
        if (wr_cmd_in) begin
          nxt_base = wr_addr_in;
          nxt_cnt  = '0;
          nxt_st   = SWC_ST_LOAD;
        end
      end
      SWC_ST_LOAD: begin
        // bytes past the buffer depth are dropped, not wrapped
        if (wr_byte_vld_in && cnt_ff < PW'(DEPTH)) begin
          nxt_buf[cnt_ff[PW-1:0] % DEPTH] = wr_byte_in;
          nxt_cnt = inc_ptr(cnt_ff);
        end
        if (stop_in) begin
          nxt_ptr = '0;
          if (secured) begin
            nxt_st = SWC_ST_WCHK;
          end else begin
            wr_t.start = 1'b1;
            nxt_st     = SWC_ST_PROG;
          end
        end
      end
      SWC_ST_WCHK: begin
        if (chk_vld_in && chk_ok_in) begin
          wr_t.start = 1'b1;
          nxt_st     = SWC_ST_PROG;
        end else if (chk_vld_in) begin
          nxt_crst  = 1'b1;
          nxt_flags = `SWC_FLAGS_INIT;
          nxt_abort = 1'b1;
          nxt_st    = SWC_ST_IDLE;
        end else if (bus_act_in || wr_cmd_in || wr_byte_vld_in) begin
          nxt_abort = 1'b1;
          nxt_st    = SWC_ST_IDLE;
        end
      end
      SWC_ST_PROG: begin
        if (ptr_ff < cnt_ff) begin
          nxt_we   = 1'b1;
          nxt_addr = AW'(base_ff + AW'(ptr_ff));
          nxt_data = buf_ff[ptr_ff % DEPTH];
          nxt_ptr  = inc_ptr(ptr_ff);
        end else if (!wr_t.busy) begin
          nxt_st = SWC_ST_IDLE;
        end
      end
      default: nxt_st = SWC_ST_RST;
    endcase
    // tamper overrides state, arm, flags and write strobe, but not the abort or crypto reset pulse, and holds the block in reset
    if (tamper) begin
      nxt_st    = SWC_ST_RST;
      nxt_arm   = 1'b1;
      nxt_flags = `SWC_FLAGS_INIT;
      nxt_we    = 1'b0;
    end
    // ready and busy flops follow the settled next state, so they change on the same edge as the state register; disabled follows tamper
    nxt_ready    = (nxt_st != SWC_ST_RST);
    nxt_disabled = tamper;
    nxt_busy     = (nxt_st == SWC_ST_PROG);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_ff       <= SWC_ST_RST;
      arm_ff      <= 1'b1;
      flags_ff    <= `SWC_FLAGS_INIT;
      cnt_ff      <= '0;
      ptr_ff      <= '0;
      base_ff     <= '0;
      ready_ff    <= 1'b0;
      disabled_ff <= 1'b0;
      busy_ff     <= 1'b0;
      crst_ff     <= 1'b0;
      abort_ff    <= 1'b0;
      we_ff       <= 1'b0;
      addr_ff     <= '0;
      data_ff     <= '0;
    end else begin
      st_ff       <= nxt_st;
      arm_ff      <= nxt_arm;
      flags_ff    <= nxt_flags;
      cnt_ff      <= nxt_cnt;
      ptr_ff      <= nxt_ptr;
      base_ff     <= nxt_base;
      ready_ff    <= nxt_ready;
      disabled_ff <= nxt_disabled;
      busy_ff     <= nxt_busy;
      crst_ff     <= nxt_crst;
      abort_ff    <= nxt_abort;
      we_ff       <= nxt_we;
      addr_ff     <= nxt_addr;
      data_ff     <= nxt_data;
    end
  end

  // data buffer needs no reset; the byte count gates its use
  always_ff @(posedge core_clk_in) begin
    buf_ff <= nxt_buf;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ready_out      = ready_ff;
  assign disabled_out   = disabled_ff;
  assign busy_out       = busy_ff;
  assign auth_out       = flags_ff[`SWC_FLAG_AUTH];
  assign enc_out        = flags_ff[`SWC_FLAG_ENC];
  assign crypto_rst_out = crst_ff;
  assign abort_out      = abort_ff;
  assign nv_we_out      = we_ff;
  assign nv_addr_out    = addr_ff;
  assign nv_data_out    = data_ff;
endmodule

/* File: bench/swc_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host side: decoded bus events
// ----------------------------------------
module swc_host (
  input  wire logic core_clk_in, // bench clock
  output logic        wr_cmd_out,  // write command
  output logic [15:0] addr_out,    // start address
  output logic        vld_out,     // data byte strobe
  output logic [7:0]  byte_out,    // data byte
  output logic        stop_out,    // stop condition
  output logic        chk_out,     // checksum command
  output logic        ok_out,      // checksum good
  output logic        act_out      // other activity
);
  initial begin
    {act_out, chk_out, stop_out, vld_out, wr_cmd_out, ok_out} = 6'h0;
    addr_out = 16'h0;
    byte_out = 8'h0;
  end
  // one event per call; qualifiers flip after use so a stale value never looks valid
  task automatic ev(input int k, input logic [15:0] a, input logic [7:0] b, input logic ok);
    @(negedge core_clk_in);
    {act_out, chk_out, stop_out, vld_out, wr_cmd_out} = 5'(1 << k);
    addr_out = a;
    byte_out = b;
    ok_out = ok;
    @(negedge core_clk_in);
    {act_out, chk_out, stop_out, vld_out, wr_cmd_out} = 5'h0;
    addr_out = ~a;
    byte_out = ~b;
    ok_out = ~ok;
  endtask
  // command, n bytes counting up from d, stop
  task automatic write(input logic [15:0] a, input logic [7:0] d, input int n);
    ev(0, a, 8'h0, 1'b0);
    for (int i = 0; i < n; i++) begin
      ev(1, 16'h0, d + 8'(i), 1'b0);
    end
    ev(2, 16'h0, 8'h0, 1'b0);
  endtask
  // sent as the very next event after the stop
  task automatic chk(input logic ok);
    ev(3, 16'h0, 8'h0, ok);
  endtask
endmodule

/* File: bench/swc_commit_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module swc_commit_chk (
  input wire logic core_clk_in,     // clock
  input wire logic srst_in,         // reset
  input wire logic volt_tamper_in,  // sensor
  input wire logic freq_tamper_in,  // sensor
  input wire logic light_tamper_in, // sensor
  input wire logic stop_in,         // stop
  input wire logic chk_vld_in,      // checksum
  input wire logic chk_ok_in,       // checksum good
  input wire logic ready_out,       // operable
  input wire logic disabled_out,    // tampered
  input wire logic busy_out,        // write cycle
  input wire logic auth_out,        // flag
  input wire logic enc_out,         // flag
  input wire logic crypto_rst_out,  // engine reset
  input wire logic abort_out,       // dropped
  input wire logic nv_we_out        // program strobe
);
  wire tamp = volt_tamper_in | freq_tamper_in | light_tamper_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  a_tamper_off: assert property (tamp |=> disabled_out ##1 !ready_out)
    else $error("tamper did not disable");
  a_tamper_flags: assert property (tamp |=> !auth_out && !enc_out)
    else $error("flags kept after tamper");
  a_rst_delay: assert property ($fell(srst_in) |-> !ready_out [*8])
    else $error("ready too soon after reset");
  a_tamper_delay: assert property ($fell(disabled_out) |-> !ready_out [*8])
    else $error("ready too soon after tamper");
  a_dis_quiet: assert property (disabled_out |-> !busy_out && !nv_we_out)
    else $error("write while disabled");
  a_bad_chk: assert property (crypto_rst_out |-> abort_out && !auth_out && !enc_out)
    else $error("bad checksum handling");
  a_abort_nowr: assert property (abort_out |-> !busy_out ##1 !nv_we_out [*3])
    else $error("aborted data written");
  a_busy_cause: assert property ($rose(busy_out) |-> $past(stop_in) || $past(chk_vld_in && chk_ok_in))
    else $error("write cycle without cause");
  a_we_in_cycle: assert property (nv_we_out |-> busy_out)
    else $error("program outside write cycle");
endmodule

bind swc_commit swc_commit_chk i_chk (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .volt_tamper_in(volt_tamper_in),
  .freq_tamper_in(freq_tamper_in), .light_tamper_in(light_tamper_in), .stop_in(stop_in),
  .chk_vld_in(chk_vld_in), .chk_ok_in(chk_ok_in), .ready_out(ready_out), .disabled_out(disabled_out),
  .busy_out(busy_out), .auth_out(auth_out), .enc_out(enc_out), .crypto_rst_out(crypto_rst_out),
  .abort_out(abort_out), .nv_we_out(nv_we_out));

/* File: bench/secure_write_commit_tamper_reset_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module secure_write_commit_tamper_reset_tb;
  localparam int WR  = 40; // short write cycle
  localparam int DLY = 8;  // short start-up delay
  int fails, check_count, n_ab, n_cr, n_busy;
  logic [23:0] wq[$];
  logic core_clk_in, srst_in, volt_tamper_in, freq_tamper_in, light_tamper_in, auth_set_in, enc_set_in;
  logic wr_cmd_in, wr_byte_vld_in, stop_in, chk_vld_in, chk_ok_in, bus_act_in;
  logic [15:0] wr_addr_in, nv_addr_out;
  logic [7:0] wr_byte_in, nv_data_out;
  logic ready_out, disabled_out, busy_out, auth_out, enc_out, crypto_rst_out, abort_out, nv_we_out;
  swc_commit #(.WR_CYCLES(WR), .DLY_CYCLES(DLY)) i_dut (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .volt_tamper_in(volt_tamper_in), .freq_tamper_in(freq_tamper_in), .light_tamper_in(light_tamper_in),
    .auth_set_in(auth_set_in), .enc_set_in(enc_set_in), .wr_cmd_in(wr_cmd_in), .wr_addr_in(wr_addr_in),
    .wr_byte_vld_in(wr_byte_vld_in), .wr_byte_in(wr_byte_in), .stop_in(stop_in), .chk_vld_in(chk_vld_in),
    .chk_ok_in(chk_ok_in), .bus_act_in(bus_act_in), .ready_out(ready_out), .disabled_out(disabled_out),
    .busy_out(busy_out), .auth_out(auth_out), .enc_out(enc_out), .crypto_rst_out(crypto_rst_out),
    .abort_out(abort_out), .nv_we_out(nv_we_out), .nv_addr_out(nv_addr_out), .nv_data_out(nv_data_out));
  swc_host i_host (.core_clk_in(core_clk_in), .wr_cmd_out(wr_cmd_in), .addr_out(wr_addr_in),
    .vld_out(wr_byte_vld_in), .byte_out(wr_byte_in), .stop_out(stop_in), .chk_out(chk_vld_in),
    .ok_out(chk_ok_in), .act_out(bus_act_in));
  // ----------------------------------------
  // clock and monitor
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // commits are logged as they happen, so a stray write shows in a later test
  always @(posedge core_clk_in) begin
    if (nv_we_out === 1'b1) wq.push_back({nv_addr_out, nv_data_out});
    n_ab += int'(abort_out === 1'b1);
    n_cr += int'(crypto_rst_out === 1'b1);
    n_busy += int'(busy_out === 1'b1);
  end
  task automatic step(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wait_ready(output int c);
    for (c = 0; c < 200 && ready_out !== 1'b1; c++) step(1);
  endtask
  task automatic set_mode(input int m);
    step(1);
    auth_set_in = (m == 0);
    enc_set_in = (m == 1);
    step(1);
    {auth_set_in, enc_set_in} = 2'h0;
  endtask
  task automatic t_reset();
    int c;
    srst_in = 1'b1;
    step(10);
    `CHK("auth", 1'b0, auth_out)
    `CHK("enc", 1'b0, enc_out)
    srst_in = 1'b0;
    wait_ready(c);
    `CHK("delay", 1'b1, c >= DLY && c < 200)
  endtask
  task automatic t_plain();
    wq = {};
    n_busy = 0;
    i_host.write(16'h00fe, 8'ha0, 2);
    step(WR + 10);
    `CHK("count", 2, wq.size())
    `CHK("b0", 24'h00fea0, wq[0])
    `CHK("b1", 24'h00ffa1, wq[1])
    `CHK("wcyc", 1'b1, n_busy >= WR - 2 && n_busy <= WR + 3)
  endtask
  // k: 0 good checksum, 1 bad checksum, 2 other activity first
  task automatic t_sec(input int m, input int k);
    wq = {};
    n_ab = 0;
    n_cr = 0;
    set_mode(m);
    i_host.write(16'h0040, 8'h5a, 1);
    if (k == 2) i_host.ev(4, 16'h0, 8'h0, 1'b0);
    else i_host.chk(k == 0);
    step(WR + 10);
    `CHK("commit", k == 0, wq.size() == 1)
    if (k == 0) `CHK("cdata", 24'h00405a, wq[0])
    `CHK("crypto", k == 1, n_cr == 1)
    `CHK("abort", k != 0, n_ab == 1)
    if (k == 1) `CHK("flag", 1'b0, auth_out | enc_out)
  endtask
  task automatic t_tamper(input int k);
    int c;
    wq = {};
    set_mode(0);
    step(2);
    `CHK("auth1", 1'b1, auth_out)
    {light_tamper_in, freq_tamper_in, volt_tamper_in} = 3'(1 << k);
    i_host.write(16'h0010, 8'h33, 1);
    `CHK("off", 1'b1, disabled_out & ~ready_out)
    `CHK("flagt", 1'b0, auth_out)
    {light_tamper_in, freq_tamper_in, volt_tamper_in} = 3'h0;
    wait_ready(c);
    `CHK("tdly", 1'b1, c >= DLY && c < 200)
    `CHK("tw", 0, wq.size())
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {srst_in, volt_tamper_in, freq_tamper_in, light_tamper_in, auth_set_in, enc_set_in} = 6'h20;
    t_reset();
    t_plain();
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) t_sec(m, k);
    end
    for (int k = 0; k < 3; k++) t_tamper(k);
    set_mode(1);
    t_reset();
    give_verdict();
  end
  // all tests need well under this many cycles
  initial begin
    step(20000);
    fails++;
    give_verdict();
  end
endmodule
